// file: hw/pattern_fifo.sv
// Purpose: small valid/ready FIFO in the pattern path
// Assumes: flip-flop storage
// Notes: DEPTH power of two
`timescale 1ns/1ps
`default_nettype none
module pattern_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   logic full;
   logic empty;
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign empty = (wp == rp);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         wp <= '0;
      else if (in_valid && !full)
      begin
         mem[wp[AW-1:0]] <= in_data;
         wp <= wp + 1'b1;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         rp <= '0;
      else if (out_ready && !empty)
         rp <= rp + 1'b1;
   end
endmodule
`default_nettype wire

// file: hw/sample_trigger_period_unit.sv
// Purpose: pattern output, trigger stage and period/frequency engine
// Assumes: one clock, mclk 25 MHz; sensor pins arrive asynchronous
// Notes: conversion arithmetic is left to the host; block reports raw counts
// How it works
// [RULE_01] circular pattern store, up to 32 entries
// [RULE_02] entry value drives four lines as binary
// [RULE_03] each sample tick advances and presents entry
// [RULE_04] pointer wraps after last defined entry
// [RULE_05] ops 5,6,7 use hardware comparator threshold
// [RULE_06] other ops compare converted value to level
// [RULE_07] sampling waits for one directed level crossing
// [RULE_08] any channel triggers; pin chosen by operation
// [RULE_09] period/frequency only first channel, alone
// [RULE_10] measurement lasts until window and interval finish
// [RULE_11] count at 150 selects count result
// [RULE_12] interval timer counts 6.4 us units
// [RULE_13] trigger edge starts both, each stops itself
// [RULE_14] edge pair follows trigger type 2 to 5
// [RULE_15] type 0 rising; type 6 error 34
// [RULE_16] period work always uses hardware comparator
// [RULE_17] wait sample time after measure, min 0.25 s
// [RULE_18] manual trigger taken off the sample clock
// [RULE_19] sample clock restarts on every trigger
// [RULE_20] trigger point records elapsed since last tick
// [RULE_21] type 6 samples on each key press
// [RULE_22] prestore samples before trigger, else trigger first
// [RULE_23] pattern pointer resets when a run starts
`timescale 1ns/1ps
`default_nettype none
module sample_trigger_period_unit #(
   parameter int DEPTH = sample_trigger_pkg::BUF_MAX,
   parameter int WINDOW_CYC = sample_trigger_pkg::WINDOW_CYC,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // pattern store load
   input wire logic pat_wr,
   input wire logic [4:0] pat_addr,
   input wire logic [3:0] pat_value,
   input wire logic [5:0] pat_count,
   // run setup
   input wire logic start,
   input wire logic stop,
   input wire logic [1:0] trig_chan,
   input wire logic [3:0] op_code,
   input wire logic others_active,
   input wire logic [2:0] trig_type,
   input wire logic prestore,
   input wire logic conv_enabled,
   input wire logic [15:0] sw_level,
   input wire logic [31:0] sample_cyc,
   input wire logic [15:0] num_samples,
   // sensor side
   input wire logic [15:0] conv_value,
   input wire logic [15:0] raw_wide,
   input wire logic [15:0] raw_low,
   input wire logic comp_pin,
   input wire logic key_pin,
   // outputs
   output logic [3:0] pattern_output_port,
   output logic [7:0] hw_threshold_sel,
   output logic sample_strobe,
   output logic [31:0] record_time,
   output logic trig_seen,
   output logic meas_done,
   output logic use_count,
   output logic [15:0] edge_count,
   output logic [23:0] interval,
   output logic [7:0] err_code,
   output logic running,
   output logic pat_out_valid
);
   logic [3:0] pattern_output_buffer [DEPTH];
   logic [4:0] rd_ptr;
   logic c_s1, c_s2, c_s3, k_s1, k_s2, k_s3;
   sample_trigger_pkg::run_state_t state;
   logic [31:0] tick_cnt;
   logic tick;
   logic [15:0] done_cnt;
   logic [15:0] prev_val;
   logic hw_mode;
   logic per_mode;
   logic rise, fall, key_ev;
   logic trig_ev;
   logic start_rise, stop_rise;
   logic [31:0] wait_cyc;
   logic [31:0] win_cnt;
   logic win_run, tmr_run, tmr_armed;
   logic gap_elapsed;
   logic [7:0] tk_div;
   logic [15:0] cur_val;
   logic fifo_in_ready;
   logic [3:0] fifo_out;
   logic fifo_valid;

   function automatic logic is_hw_op(input logic [3:0] op);
      is_hw_op = (op == sample_trigger_pkg::OP_PERIOD) || (op == sample_trigger_pkg::OP_FREQ)
         || (op == sample_trigger_pkg::OP_COUNT);
   endfunction
   function automatic logic is_wide_op(input logic [3:0] op);
      is_wide_op = (op == sample_trigger_pkg::OP_WIDE_V)
         || (op == sample_trigger_pkg::OP_CURRENT) || is_hw_op(op);
   endfunction

   // ------------------------------------------------
   // input synchronisers
   // ------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         c_s1 <= 1'b0;
         c_s2 <= 1'b0;
         c_s3 <= 1'b0;
         k_s1 <= 1'b0;
         k_s2 <= 1'b0;
         k_s3 <= 1'b0;
      end
      else
      begin
         c_s1 <= comp_pin;
         c_s2 <= c_s1;
         c_s3 <= c_s2;
         k_s1 <= key_pin;
         k_s2 <= k_s1;
         k_s3 <= k_s2;
      end
   end

   // ------------------------------------------------
   // trigger decode
   // ------------------------------------------------
   assign hw_mode = (trig_chan == 2'h0) && is_hw_op(op_code); // RULE_05
   assign per_mode = (op_code == sample_trigger_pkg::OP_PERIOD)
      || (op_code == sample_trigger_pkg::OP_FREQ);
   // converted value when enabled, else low-range pin unless operation needs the wide one
   assign cur_val = conv_enabled ? conv_value
      : (is_wide_op(op_code) ? raw_wide : raw_low); // RULE_08 RULE_06
   assign start_rise = start;
   assign stop_rise = stop;
   assign key_ev = k_s2 && !k_s3; // RULE_18
   always_comb
   begin
      rise = 1'b0;
      fall = 1'b0;
      if (hw_mode || per_mode) // RULE_16
      begin
         rise = c_s2 && !c_s3;
         fall = !c_s2 && c_s3;
      end
      else
      begin
         rise = ($signed(prev_val) < $signed(sw_level)) && ($signed(cur_val) >= $signed(sw_level));
         fall = ($signed(prev_val) >= $signed(sw_level)) && ($signed(cur_val) < $signed(sw_level));
      end
   end
   // falling types start on a fall, manual and key types on a key press, type 0 at once outside period work, the rest on a rise
   always_comb
   begin
      case (trig_type)
         sample_trigger_pkg::TT_MANUAL,
         sample_trigger_pkg::TT_KEY: trig_ev = key_ev; // RULE_18
         sample_trigger_pkg::TT_FF,
         sample_trigger_pkg::TT_FR: trig_ev = fall; // RULE_14
         sample_trigger_pkg::TT_NONE: trig_ev = per_mode ? rise : 1'b1; // RULE_15
         default: trig_ev = rise;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         prev_val <= 16'h0000;
      else
         prev_val <= cur_val;
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         hw_threshold_sel <= 8'h00;
      else
         hw_threshold_sel <= {7'h00, hw_mode};
   end

   // ------------------------------------------------
   // run control
   // ------------------------------------------------
   // sample clock period, floor of 0.25 s in period work
   assign wait_cyc = (per_mode && sample_cyc < WINDOW_CYC) ? WINDOW_CYC : sample_cyc; // RULE_17
   assign tick = (tick_cnt + 32'h0000_0001 >= wait_cyc);
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state <= sample_trigger_pkg::ST_IDLE;
         err_code <= sample_trigger_pkg::ERR_NONE;
      end
      else if (stop_rise)
         state <= sample_trigger_pkg::ST_IDLE;
      else
      begin
         case (state)
            sample_trigger_pkg::ST_IDLE:
               if (start_rise)
               begin
                  if (per_mode && trig_type == sample_trigger_pkg::TT_KEY)
                     err_code <= sample_trigger_pkg::ERR_TRIG; // RULE_15
                  else if (per_mode && others_active)
                     err_code <= sample_trigger_pkg::ERR_CHAN; // RULE_09
                  else if (is_hw_op(op_code) && trig_chan != 2'h0)
                     err_code <= sample_trigger_pkg::ERR_CHAN; // RULE_09
                  else
                  begin
                     err_code <= sample_trigger_pkg::ERR_NONE;
                     state <= sample_trigger_pkg::ST_ARM;
                  end
               end
            sample_trigger_pkg::ST_ARM:
               if (trig_ev) // RULE_07
                  state <= per_mode ? sample_trigger_pkg::ST_MEAS : sample_trigger_pkg::ST_RUN;
            sample_trigger_pkg::ST_RUN:
               if (sample_strobe && done_cnt + 16'h0001 >= num_samples)
                  state <= sample_trigger_pkg::ST_IDLE;
            sample_trigger_pkg::ST_MEAS:
               if (!win_run && !tmr_run) // RULE_10
                  state <= (done_cnt + 16'h0001 >= num_samples) ? sample_trigger_pkg::ST_IDLE
                     : sample_trigger_pkg::ST_GAP;
            sample_trigger_pkg::ST_GAP:
               if ((tick || gap_elapsed) && trig_ev) // RULE_17
                  state <= sample_trigger_pkg::ST_MEAS;
            default: state <= sample_trigger_pkg::ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         running <= 1'b0;
      else
         running <= (state != sample_trigger_pkg::ST_IDLE);
   end
   // tick and trigger seldom share a cycle, so the elapsed gap is held
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         gap_elapsed <= 1'b0;
      else if (state != sample_trigger_pkg::ST_GAP)
         gap_elapsed <= 1'b0;
      else if (tick)
         gap_elapsed <= 1'b1; // RULE_17
   end

   // ------------------------------------------------
   // sample clock and record time
   // ------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         tick_cnt <= 32'h0000_0000;
      else if (state == sample_trigger_pkg::ST_ARM && trig_ev)
         tick_cnt <= 32'h0000_0000; // RULE_19
      else if (state == sample_trigger_pkg::ST_MEAS || tick)
         tick_cnt <= 32'h0000_0000;
      else
         tick_cnt <= tick_cnt + 32'h0000_0001;
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         sample_strobe <= 1'b0;
         record_time <= 32'h0000_0000;
         trig_seen <= 1'b0;
      end
      else
      begin
         sample_strobe <= 1'b0;
         trig_seen <= 1'b0;
         if (state == sample_trigger_pkg::ST_ARM && trig_ev)
         begin
            // period work advances the pattern on completion, not at the trigger
            sample_strobe <= !per_mode; // RULE_22
            trig_seen <= 1'b1;
            record_time <= tick_cnt + 32'h0000_0001; // RULE_20
         end
         else if (state == sample_trigger_pkg::ST_ARM && prestore && tick)
         begin
            sample_strobe <= 1'b1; // RULE_22
            record_time <= wait_cyc;
         end
         else if (state == sample_trigger_pkg::ST_RUN
            && (trig_type == sample_trigger_pkg::TT_KEY ? key_ev : tick))
         begin
            sample_strobe <= 1'b1; // RULE_21
            record_time <= tick_cnt + 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         done_cnt <= 16'h0000;
      else if (state == sample_trigger_pkg::ST_IDLE)
         done_cnt <= 16'h0000;
      else if (sample_strobe && state == sample_trigger_pkg::ST_RUN)
         done_cnt <= done_cnt + 16'h0001;
      else if (state == sample_trigger_pkg::ST_MEAS && !win_run && !tmr_run)
         done_cnt <= done_cnt + 16'h0001;
   end

   // ------------------------------------------------
   // period and frequency engine
   // ------------------------------------------------
   logic entering;
   logic stop_edge;
   assign entering = (state != sample_trigger_pkg::ST_MEAS) && trig_ev
      && (state == sample_trigger_pkg::ST_ARM
      || (state == sample_trigger_pkg::ST_GAP && (tick || gap_elapsed)));
   // edge that ends the interval
   assign stop_edge = (trig_type == sample_trigger_pkg::TT_FF || trig_type == sample_trigger_pkg::TT_RF)
      ? fall : rise; // RULE_14
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         win_cnt <= 32'h0000_0000;
         win_run <= 1'b0;
         edge_count <= 16'h0000;
      end
      else if (entering && per_mode)
      begin
         win_cnt <= 32'h0000_0000; // RULE_13
         win_run <= 1'b1;
         edge_count <= 16'h0000;
      end
      else if (win_run)
      begin
         if (rise)
            edge_count <= edge_count + 16'h0001;
         if (win_cnt + 32'h0000_0001 >= WINDOW_CYC)
            win_run <= 1'b0; // RULE_13
         win_cnt <= win_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         tmr_run <= 1'b0;
         tmr_armed <= 1'b0;
         tk_div <= 8'h00;
         interval <= 24'h00_0000;
      end
      else if (entering && per_mode)
      begin
         tmr_run <= 1'b1;
         tmr_armed <= 1'b0;
         tk_div <= 8'h00;
         interval <= 24'h00_0000;
      end
      else if (tmr_run)
      begin
         tmr_armed <= 1'b1;
         if (tmr_armed && stop_edge)
            tmr_run <= 1'b0; // RULE_13
         if (tk_div == 8'(sample_trigger_pkg::TICK_CYC - 1))
         begin
            tk_div <= 8'h00;
            interval <= interval + 24'h00_0001; // RULE_12
         end
         else
            tk_div <= tk_div + 8'h01;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         meas_done <= 1'b0;
         use_count <= 1'b0;
      end
      else
      begin
         meas_done <= 1'b0;
         if (state == sample_trigger_pkg::ST_MEAS && !win_run && !tmr_run)
         begin
            meas_done <= 1'b1;
            use_count <= (edge_count >= 16'(sample_trigger_pkg::EDGE_LIMIT)); // RULE_11
         end
      end
   end

   // ------------------------------------------------
   // pattern output buffer
   // ------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (pat_wr && 32'(pat_addr) < DEPTH)
         pattern_output_buffer[pat_addr] <= pat_value; // RULE_01
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         rd_ptr <= 5'h00;
      else if (start_rise && state == sample_trigger_pkg::ST_IDLE)
         rd_ptr <= 5'h00; // RULE_23
      else if ((sample_strobe || meas_done) && fifo_in_ready && pat_count != 6'h00)
      begin
         if (6'(rd_ptr) + 6'h01 >= pat_count)
            rd_ptr <= 5'h00; // RULE_04
         else
            rd_ptr <= rd_ptr + 5'h01; // RULE_03
      end
   end
   pattern_fifo #(
      .WIDTH(sample_trigger_pkg::NIB_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_data(pattern_output_buffer[rd_ptr]),
      .in_valid((sample_strobe || meas_done) && pat_count != 6'h00),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(1'b1)
   );
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pattern_output_port <= 4'h0;
         pat_out_valid <= 1'b0;
      end
      else
      begin
         pat_out_valid <= fifo_valid;
         if (fifo_valid)
            pattern_output_port <= fifo_out; // RULE_02
      end
   end

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   chk_pat_wrap: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_04
      (pat_count != 6'h00) |-> (6'(rd_ptr) < pat_count || $past(pat_count) != pat_count))
      else $error("pattern pointer beyond count");
   chk_ptr_reset: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_23
      (start && state == sample_trigger_pkg::ST_IDLE) |=> rd_ptr == 5'h00)
      else $error("pointer not reset at start");
   chk_trig_err: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_15
      (state == sample_trigger_pkg::ST_IDLE && start && !stop && per_mode
      && trig_type == sample_trigger_pkg::TT_KEY) |=> err_code == sample_trigger_pkg::ERR_TRIG
      && state == sample_trigger_pkg::ST_IDLE)
      else $error("type 6 period not refused");
   chk_arm_wait: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_07
      (state == sample_trigger_pkg::ST_ARM && !trig_ev && !stop) |=> state
      == sample_trigger_pkg::ST_ARM)
      else $error("left arm without trigger");
   chk_clk_restart: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_19
      (state == sample_trigger_pkg::ST_ARM && trig_ev) |=> tick_cnt == 32'h0000_0000 && trig_seen)
      else $error("sample clock not restarted");
   chk_meas_span: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_10
      meas_done |-> $past(!win_run) && $past(!tmr_run))
      else $error("measurement ended early");
   chk_count_sel: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_11
      meas_done |-> use_count == ($past(edge_count) >= 16'(sample_trigger_pkg::EDGE_LIMIT)))
      else $error("wrong result selection");
   chk_hw_comp: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_05
      (trig_chan == 2'h0 && op_code == sample_trigger_pkg::OP_COUNT) |=> hw_threshold_sel[0]
      || $changed(op_code) || $changed(trig_chan))
      else $error("comparator not selected");
endmodule
`default_nettype wire

// file: hw/sample_trigger_pkg.sv
// Purpose: shared constants for the sample/trigger/period unit
// Assumes: 25 MHz mclk
// Notes: times in their own units, cycle counts derived
package sample_trigger_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int CLK_NS = 40;
   // timer resolution, 6.4 us
   localparam int TICK_NS = 6400;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // edge count window, 0.25 s
   localparam int WINDOW_MS = 250;
   localparam int WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS;
   localparam int EDGE_LIMIT = 150;
   localparam int BUF_MAX = 32;
   localparam int NIB_W = 4;
   // operation codes
   localparam logic [3:0] OP_WIDE_V = 4'h2;
   localparam logic [3:0] OP_CURRENT = 4'h3;
   localparam logic [3:0] OP_PERIOD = 4'h5;
   localparam logic [3:0] OP_FREQ = 4'h6;
   localparam logic [3:0] OP_COUNT = 4'h7;
   // trigger types
   localparam logic [2:0] TT_NONE = 3'h0;
   localparam logic [2:0] TT_MANUAL = 3'h1;
   localparam logic [2:0] TT_RR = 3'h2;
   localparam logic [2:0] TT_FF = 3'h3;
   localparam logic [2:0] TT_RF = 3'h4;
   localparam logic [2:0] TT_FR = 3'h5;
   localparam logic [2:0] TT_KEY = 3'h6;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_TRIG = 8'h22;
   localparam logic [7:0] ERR_CHAN = 8'h23;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_ARM = 5'b0_0010,
      ST_RUN = 5'b0_0100,
      ST_MEAS = 5'b0_1000,
      ST_GAP = 5'b1_0000
   } run_state_t;
endpackage

// file: tb/sensor_model.sv
// Purpose: far-side sensor model: comparator pin, key pin, wide-range value
// Assumes: bench clock domain, half period given in mclk cycles
// Notes: comparator pin stands low while no wave is asked for
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
   // bench control
   input wire logic mclk,
   input wire logic [15:0] half,
   input wire logic key_req,
   input wire logic [15:0] wide_lvl,
   // sensor pins
   output logic comp_pin,
   output logic key_pin,
   output logic [15:0] raw_wide
);
   logic [15:0] cnt = 16'h0000;
   initial comp_pin = 1'b0;
   // ----------------------------------------
   // square wave, 50 percent duty
   // ----------------------------------------
   always @(posedge mclk)
   begin
      if (half == 16'h0000)
      begin
         comp_pin <= 1'b0;
         cnt <= 16'h0000;
      end
      else if (cnt >= half - 16'h0001)
      begin
         comp_pin <= ~comp_pin;
         cnt <= 16'h0000;
      end
      else
         cnt <= cnt + 16'h0001;
   end
   assign key_pin = key_req;
   assign raw_wide = wide_lvl;
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the sample/trigger/period unit
// Assumes: short count window so a run stays small
// Notes: edge counts get a small tolerance for synchroniser skew
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WIN = 2000;
   localparam int SCYC = 20;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic pat_wr = 1'b0;
   logic [4:0] pat_addr = 5'h00;
   logic [3:0] pat_value = 4'h0;
   logic start = 1'b0;
   logic stop = 1'b0;
   logic prestore = 1'b0;
   logic [1:0] trig_chan = 2'h0;
   logic [3:0] op_code = 4'h0;
   logic others_active = 1'b0;
   logic [2:0] trig_type = 3'h0;
   logic [15:0] sw_level = 16'h0064;
   logic [31:0] sample_cyc = 32'h0000_0014;
   logic [15:0] half = 16'h0000;
   logic key_req = 1'b0;
   logic [15:0] wide_lvl = 16'h0000;
   logic comp_pin, key_pin, sample_strobe, trig_seen, meas_done, use_count, running, pov;
   logic [15:0] raw_wide, edge_count;
   logic [3:0] port;
   logic [7:0] hw_sel, err_code;
   logic [31:0] record_time;
   logic [23:0] interval;
   int error_cnt = 0;
   int n_tests = 0;
   int now = 0;
   int n_str = 0;
   int c, s0, tprev;
   logic [3:0] pv [5] = '{4'h5, 4'hf, 4'h0, 4'ha, 4'h3};
   logic [2:0] tts [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
   int ivl [5] = '{20, 20, 20, 10, 10};
   always #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      now++;
      if (sample_strobe === 1'b1)
         n_str++;
   end
   sensor_model partner (.mclk(mclk), .half(half), .key_req(key_req), .wide_lvl(wide_lvl),
      .comp_pin(comp_pin), .key_pin(key_pin), .raw_wide(raw_wide));
   sample_trigger_period_unit #(.WINDOW_CYC(WIN)) uut (
      .mclk(mclk), .rst_b(rst_b), .pat_wr(pat_wr), .pat_addr(pat_addr),
      .pat_value(pat_value), .pat_count(6'h05), .start(start), .stop(stop),
      .trig_chan(trig_chan), .op_code(op_code), .others_active(others_active),
      .trig_type(trig_type), .prestore(prestore), .conv_enabled(1'b0), .sw_level(sw_level),
      .sample_cyc(sample_cyc), .num_samples(16'h0064), .conv_value(16'h0000),
      .raw_wide(raw_wide), .raw_low(16'h0000), .comp_pin(comp_pin), .key_pin(key_pin),
      .pattern_output_port(port), .hw_threshold_sel(hw_sel), .sample_strobe(sample_strobe),
      .record_time(record_time), .trig_seen(trig_seen), .meas_done(meas_done),
      .use_count(use_count), .edge_count(edge_count), .interval(interval),
      .err_code(err_code), .running(running), .pat_out_valid(pov));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask
   // which 0 waits for a sample strobe, 1 for a finished measurement
   task automatic wait_ev(input int which, input int lim, output int cyc);
      cyc = 0;
      while (((which == 0) ? sample_strobe : meas_done) !== 1'b1)
      begin
         tick(1);
         cyc++;
         if (cyc > lim)
         begin
            error_cnt++;
            report_and_stop();
         end
      end
   endtask
   task automatic run(input logic [3:0] op, input logic [2:0] tt, input logic oth);
      op_code = op;
      trig_type = tt;
      others_active = oth;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(1);
   endtask
   task automatic halt();
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
      tick(2);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      tick(1);
      cmp(32'(running), 32'h0000_0000);
      cmp(32'(port), 32'h0000_0000);
      for (int i = 0; i < 5; i++)
      begin
         pat_wr = 1'b1;
         pat_addr = 5'(i);
         pat_value = pv[i];
         tick(1);
      end
      pat_wr = 1'b0;
      // manual trigger, then pattern stream with wrap
      run(sample_trigger_pkg::OP_WIDE_V, sample_trigger_pkg::TT_MANUAL, 1'b0);
      s0 = n_str;
      tick(30);
      cmp(32'(n_str), 32'(s0));
      key_req = 1'b1;
      wait_ev(0, 10, c);
      cmp(32'(trig_seen), 32'h0000_0001);
      for (int i = 0; i < 7; i++)
      begin
         if (i > 0)
         begin
            wait_ev(0, SCYC + 2, c);
            cmp(32'(now - tprev), 32'(SCYC));
         end
         tprev = now;
         tick(2);
         cmp(32'(port), 32'(pv[i % 5]));
         cmp(32'(pov), 32'h0000_0001);
      end
      key_req = 1'b0;
      halt();
      // software level trigger on the wide-range value
      run(sample_trigger_pkg::OP_WIDE_V, sample_trigger_pkg::TT_RR, 1'b0);
      s0 = n_str;
      tick(20);
      cmp(32'(n_str), 32'(s0));
      cmp(32'(hw_sel[0]), 32'h0000_0000);
      wide_lvl = 16'h00c8;
      wait_ev(0, 10, c);
      cmp(32'(trig_seen), 32'h0000_0001);
      tick(3);
      cmp(32'(port), 32'(pv[0]));
      halt();
      // prestore: tick samples, then the trigger point's own elapsed time
      wide_lvl = 16'h0000;
      prestore = 1'b1;
      run(sample_trigger_pkg::OP_WIDE_V, sample_trigger_pkg::TT_RR, 1'b0);
      wait_ev(0, SCYC + 2, c);
      cmp(32'(record_time), 32'(SCYC));
      tick(4);
      wide_lvl = 16'h00c8;
      wait_ev(0, 3, c);
      cmp(32'(record_time), 32'h0000_0005);
      prestore = 1'b0;
      halt();
      // type 6: each key press is a sample, timed from the last press
      run(sample_trigger_pkg::OP_WIDE_V, sample_trigger_pkg::TT_KEY, 1'b0);
      key_req = 1'b1;
      wait_ev(0, 10, c);
      key_req = 1'b0;
      tick(9);
      key_req = 1'b1;
      wait_ev(0, 10, c);
      cmp(32'(record_time), 32'h0000_000c);
      key_req = 1'b0;
      halt();
      // fast wave: count wins, repeat waits a sample time
      half = 16'h0004;
      sample_cyc = 32'(2 * WIN);
      run(sample_trigger_pkg::OP_FREQ, sample_trigger_pkg::TT_RR, 1'b0);
      cmp(32'(hw_sel[0]), 32'h0000_0001);
      wait_ev(1, 3 * WIN, c);
      cmp(32'(use_count), 32'h0000_0001);
      cmp_rng(32'(edge_count), 32'd248, 32'd252);
      tick(1);
      wait_ev(1, 4 * WIN, c);
      cmp_rng(32'(c), 32'(3 * WIN - 4), 32'(3 * WIN + 40));
      halt();
      // slow wave: interval wins, edge pair per trigger type
      half = 16'd1600;
      for (int i = 0; i < 5; i++)
      begin
         run(sample_trigger_pkg::OP_PERIOD, tts[i], 1'b0);
         wait_ev(1, 12000, c);
         cmp(32'(use_count), 32'h0000_0000);
         cmp_rng(32'(interval), 32'(ivl[i] - 1), 32'(ivl[i] + 1));
         halt();
      end
      half = 16'h0000;
      // refused setups
      run(sample_trigger_pkg::OP_FREQ, sample_trigger_pkg::TT_KEY, 1'b0);
      cmp(32'(err_code), 32'(sample_trigger_pkg::ERR_TRIG));
      cmp(32'(running), 32'h0000_0000);
      run(sample_trigger_pkg::OP_PERIOD, sample_trigger_pkg::TT_RR, 1'b1);
      cmp(32'(err_code), 32'(sample_trigger_pkg::ERR_CHAN));
      trig_chan = 2'h1;
      run(sample_trigger_pkg::OP_FREQ, sample_trigger_pkg::TT_RR, 1'b0);
      cmp(32'(err_code), 32'(sample_trigger_pkg::ERR_CHAN));
      report_and_stop();
   end
endmodule
`default_nettype wire
